// ==== drc_pkg.sv ====
// package of constants and types for the dac reset/reference control block
// assumes: 24-bit serial frames, two 12-bit channels, 100 MHz system clock
package drc_pkg;

  // ==========================================================================
  // frame layout
  localparam int          FRAME_BITS      = 24;
  localparam int          CNT_W           = 5;
  localparam logic [4:0]  FRAME_BITS_CNT  = 5'h18;
  localparam logic [4:0]  CNT_MAX         = 5'h1f;
  localparam int          CMD_MSB         = 23;
  localparam int          CMD_LSB         = 20;
  localparam int          ADDR_CHAN_A_POS = 16;
  localparam int          ADDR_CHAN_B_POS = 19;
  localparam int          DATA_MSB        = 15;
  localparam int          DATA_LSB        = 4;
  localparam int          REF_BIT_POS     = 0;
  localparam int          MASK_A_POS      = 0;
  localparam int          MASK_B_POS      = 3;

  // ==========================================================================
  // command codes
  localparam logic [3:0]  CMD_WRITE_INPUT  = 4'h1;
  localparam logic [3:0]  CMD_UPDATE_DAC   = 4'h2;
  localparam logic [3:0]  CMD_WRITE_UPDATE = 4'h3;
  localparam logic [3:0]  CMD_LOAD_DAC_STROBE_MASK    = 4'h5;
  localparam logic [3:0]  CMD_SOFT_RESET   = 4'h6;
  localparam logic [3:0]  CMD_REF_SETUP    = 4'h7;

  // ==========================================================================
  // data widths and reset values
  localparam int          DATA_W           = 12;
  localparam int          NUM_CHAN         = 2;
  localparam logic [11:0] ZERO_SCALE       = 12'h000;
  localparam logic [11:0] MID_SCALE        = 12'h800;
  localparam logic        REF_DISABLE_RST  = 1'h0;
  localparam logic [1:0]  LOAD_DAC_STROBE_MASK_RST    = 2'h0;

  // ==========================================================================
  // timing
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          POR_SETTLE_NS    = 200;
  localparam int          POR_CYCLES       = (POR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SETTLE_W         = 8;

  // ==========================================================================
  // power-on sequencer states
  typedef enum logic [2:0] {
    ST_INIT   = 3'b001,
    ST_SETTLE = 3'b010,
    ST_RUN    = 3'b100
  } drc_state_e;

endpackage

// ==== drc_serial_rx.sv ====
// serial frame receiver on the link clock
// assumes: data shifted on falling serial clock while frame sync is low
module drc_serial_rx (
  input  wire logic                         sclk_i,    // serial clock
  input  wire logic                         sync_n_i,  // frame sync, active low
  input  wire logic                         sdin_i,    // serial data, msb first
  output logic [drc_pkg::FRAME_BITS-1:0]    word_o,    // last bits shifted in
  output logic [drc_pkg::CNT_W-1:0]         bit_cnt_o  // edges seen this frame
);
  import drc_pkg::*;

  logic first_edge;

  // ==========================================================================
  // frame start flag, armed while sync is high (no clock edge needed)
  always_ff @(negedge sclk_i or posedge sync_n_i) begin
    if (sync_n_i) begin
      first_edge <= 1'b1;
    end else begin
      first_edge <= 1'b0;
    end
  end

  // ==========================================================================
  // shift register and edge count; both stay frozen once sync rises
  always_ff @(negedge sclk_i) begin
    if (!sync_n_i) begin
      word_o <= {word_o[FRAME_BITS-2:0], sdin_i};
      if (first_edge) begin
        bit_cnt_o <= 5'h01;
      end else if (bit_cnt_o != CNT_MAX) begin
        bit_cnt_o <= bit_cnt_o + 5'h01;
      end
    end
  end

endmodule // drc_serial_rx

// ==== drc_ctrl.sv ====
// reset, power-on clear and reference control of a dual-channel dac
// assumes: serial link on its own clock, pins asynchronous to clk_sys_i,
// sys_rst_i models the power-on reset of the device
//
// Operation
// - reset pin low forces clear code
// - cleared value held until next write
// - no output update while reset pin low
// - command 0110 returns to power-on code
// - load strobe ignored during power-on reset
// - initialisation waits for reset pin release
// - power-up level chosen by select pin
// - power-up level kept until valid write
// - command 0111 selects reference setup
// - reference on at power-up, bit0 disables
// - command top four bits, bit0 reference
// - 24-bit word, valid on sync rising
// - strobe falling edge loads unmasked channels
module drc_ctrl (
  input  wire logic                      clk_sys_i,             // system clock
  input  wire logic                      sys_rst_i,             // power-on reset
  input  wire logic                      sclk_i,                // serial clock
  input  wire logic                      sync_n_i,              // frame sync
  input  wire logic                      sdin_i,                // serial data
  input  wire logic                      reset_n_i,             // hardware reset pin
  input  wire logic                      reset_level_select_i,  // 0 zero, 1 mid
  input  wire logic                      load_dac_strobe_n_i,   // load strobe pin
  output logic [drc_pkg::DATA_W-1:0]     dac_a_code_o,          // channel a code
  output logic [drc_pkg::DATA_W-1:0]     dac_b_code_o,          // channel b code
  output logic                           ref_enabled_o,         // reference on
  output logic                           init_done_o            // init complete
);
  import drc_pkg::*;

  // ==========================================================================
  // helpers
  function automatic logic [DATA_W-1:0] clear_code(input logic sel);
    clear_code = sel ? MID_SCALE : ZERO_SCALE;
  endfunction

  function automatic logic chan_hit(input logic [FRAME_BITS-1:0] w, input int ch);
    chan_hit = (ch == 0) ? w[ADDR_CHAN_A_POS] : w[ADDR_CHAN_B_POS];
  endfunction

  function automatic logic chan_masked(input logic [1:0] m, input int ch);
    chan_masked = m[ch];
  endfunction

  // ==========================================================================
  // declarations
  logic [FRAME_BITS-1:0] rx_word;
  logic [CNT_W-1:0]      rx_cnt;

  logic                  sync_meta;
  logic                  sync_q;
  logic                  sync_prev;
  logic                  rst_meta;
  logic                  rst_q;
  logic                  sel_meta;
  logic                  sel_q;
  logic                  load_dac_strobe_meta;
  logic                  load_dac_strobe_q;
  logic                  load_dac_strobe_prev;

  logic                  frame_end;
  logic                  frame_valid;
  logic [3:0]            frame_cmd;
  logic [DATA_W-1:0]     frame_data;
  logic                  soft_reset_hit;
  logic                  load_dac_strobe_fall;

  drc_state_e            state;
  drc_state_e            next_state;
  logic [SETTLE_W-1:0]   settle_cnt;
  logic                  clear_sel;
  logic                  running;

  logic [DATA_W-1:0]     input_reg [NUM_CHAN];
  logic [DATA_W-1:0]     dac_reg   [NUM_CHAN];
  logic [1:0]            load_dac_strobe_mask;
  logic                  internal_ref_disable;

  // ==========================================================================
  // serial receiver in the link clock domain
  drc_serial_rx u_rx (
    .sclk_i    (sclk_i),
    .sync_n_i  (sync_n_i),
    .sdin_i    (sdin_i),
    .word_o    (rx_word),
    .bit_cnt_o (rx_cnt)
  );

  // ==========================================================================
  // pin synchronisers
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sync_meta <= 1'b1;
      sync_q    <= 1'b1;
      sync_prev <= 1'b1;
    end else begin
      sync_meta <= sync_n_i;
      sync_q    <= sync_meta;
      sync_prev <= sync_q;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rst_meta <= 1'b0;
      rst_q    <= 1'b0;
      sel_meta <= 1'b0;
      sel_q    <= 1'b0;
    end else begin
      rst_meta <= reset_n_i;
      rst_q    <= rst_meta;
      sel_meta <= reset_level_select_i;
      sel_q    <= sel_meta;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      load_dac_strobe_meta <= 1'b1;
      load_dac_strobe_q    <= 1'b1;
      load_dac_strobe_prev <= 1'b1;
    end else begin
      load_dac_strobe_meta <= load_dac_strobe_n_i;
      load_dac_strobe_q    <= load_dac_strobe_meta;
      load_dac_strobe_prev <= load_dac_strobe_q;
    end
  end

  // ==========================================================================
  // frame decode
  // word and count are frozen in the link domain while sync is high, so they
  // are safe to read once the synchronised sync level shows the rising edge
  assign frame_end      = sync_q & ~sync_prev;
  assign frame_valid    = frame_end && (rx_cnt == FRAME_BITS_CNT);
  assign frame_cmd      = rx_word[CMD_MSB:CMD_LSB];
  assign frame_data     = rx_word[DATA_MSB:DATA_LSB];
  assign soft_reset_hit = running && frame_valid && (frame_cmd == CMD_SOFT_RESET);
  assign running        = (state == ST_RUN);
  assign load_dac_strobe_fall      = load_dac_strobe_prev & ~load_dac_strobe_q & running;

  // ==========================================================================
  // power-on sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_INIT: begin
        if (rst_q) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (!rst_q) begin
          next_state = ST_INIT;
        end else if (settle_cnt == SETTLE_W'(POR_CYCLES - 1)) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_INIT;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state <= ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      settle_cnt <= '0;
    end else if (state == ST_SETTLE) begin
      settle_cnt <= settle_cnt + SETTLE_W'(1);
    end else begin
      settle_cnt <= '0;
    end
  end

  // select level is tracked until power-on completes, then frozen
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      clear_sel <= 1'b0;
    end else if (!running) begin
      clear_sel <= sel_q;
    end
  end

  // ==========================================================================
  // input and dac registers
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        input_reg[i] <= ZERO_SCALE;
        dac_reg[i]   <= ZERO_SCALE;
      end
    end else if (!running || !rst_q || soft_reset_hit) begin
      // hold the clear code; released only by a later write
      for (int i = 0; i < NUM_CHAN; i++) begin
        input_reg[i] <= clear_code(clear_sel);
        dac_reg[i]   <= clear_code(clear_sel);
      end
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (load_dac_strobe_fall && !chan_masked(load_dac_strobe_mask, i)) begin
          dac_reg[i] <= input_reg[i];
        end
        if (frame_valid && chan_hit(rx_word, i)) begin
          case (frame_cmd)
            CMD_WRITE_INPUT: begin
              input_reg[i] <= frame_data;
              if (!load_dac_strobe_q) begin
                dac_reg[i] <= frame_data;
              end
            end
            CMD_UPDATE_DAC: begin
              dac_reg[i] <= input_reg[i];
            end
            CMD_WRITE_UPDATE: begin
              input_reg[i] <= frame_data;
              dac_reg[i]   <= frame_data;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // ==========================================================================
  // load mask register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || soft_reset_hit) begin
      load_dac_strobe_mask <= LOAD_DAC_STROBE_MASK_RST;
    end else if (running && frame_valid && frame_cmd == CMD_LOAD_DAC_STROBE_MASK) begin
      load_dac_strobe_mask <= {rx_word[MASK_B_POS], rx_word[MASK_A_POS]};
    end
  end

  // ==========================================================================
  // reference setup register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || soft_reset_hit) begin
      internal_ref_disable <= REF_DISABLE_RST;
    end else if (running && frame_valid && frame_cmd == CMD_REF_SETUP) begin
      internal_ref_disable <= rx_word[REF_BIT_POS];
    end
  end

  // ==========================================================================
  // outputs
  assign dac_a_code_o  = dac_reg[0];
  assign dac_b_code_o  = dac_reg[1];
  assign ref_enabled_o = ~internal_ref_disable;
  assign init_done_o   = running;

endmodule // drc_ctrl

// ==== drc_ctrl_asserts.sv ====
// concurrent checks on the ports of the dac reset/reference control block
// assumes: bound to drc_ctrl, every pin sampled on clk_sys_i
module drc_ctrl_asserts (
  input wire logic                      clk_sys_i,            // system clock
  input wire logic                      sys_rst_i,            // power-on reset
  input wire logic                      sclk_i,               // serial clock
  input wire logic                      sync_n_i,             // frame sync
  input wire logic                      sdin_i,               // serial data
  input wire logic                      reset_n_i,            // reset pin
  input wire logic                      reset_level_select_i, // clear level
  input wire logic                      load_dac_strobe_n_i,  // load strobe
  input wire logic [drc_pkg::DATA_W-1:0] dac_a_code_o,        // channel a
  input wire logic [drc_pkg::DATA_W-1:0] dac_b_code_o,        // channel b
  input wire logic                      ref_enabled_o,        // reference on
  input wire logic                      init_done_o           // init complete
);
  import drc_pkg::*;
  logic       sync_q;
  logic       load_dac_strobe_q;
  logic [3:0] quiet;
  // ==========================================================================
  // cycles since the last event allowed to move an output
  always_ff @(posedge clk_sys_i) begin
    sync_q <= sync_n_i;
    load_dac_strobe_q <= load_dac_strobe_n_i;
  end
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !reset_n_i || (sync_n_i && !sync_q) || (load_dac_strobe_q && !load_dac_strobe_n_i)) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hf) begin
      quiet <= quiet + 4'h1;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  chk_rst_values: assert property ($fell(sys_rst_i) |-> dac_a_code_o == ZERO_SCALE &&
    dac_b_code_o == ZERO_SCALE && ref_enabled_o && !init_done_o) else $error("bad reset values");
  chk_init_wait: assert property ($rose(init_done_o) |-> $past(reset_n_i, 20))
    else $error("init finished under reset pin");
  chk_init_mid: assert property ((!init_done_o && reset_level_select_i)[*5] |->
    dac_a_code_o == MID_SCALE && dac_b_code_o == MID_SCALE) else $error("no midscale");
  chk_init_zero: assert property ((!init_done_o && !reset_level_select_i)[*5] |->
    dac_a_code_o == ZERO_SCALE && dac_b_code_o == ZERO_SCALE) else $error("no zero scale");
  chk_init_ref: assert property (!init_done_o |-> ref_enabled_o)
    else $error("reference off at power-up");
  chk_hw_clear: assert property ((!reset_n_i && init_done_o)[*5] |-> dac_a_code_o == dac_b_code_o
    && (dac_a_code_o == ZERO_SCALE || dac_a_code_o == MID_SCALE)) else $error("not cleared");
  chk_hw_block: assert property ((!reset_n_i && init_done_o)[*5] |=>
    $stable(dac_a_code_o) && $stable(dac_b_code_o)) else $error("update under reset pin");
  chk_quiet_dac: assert property (init_done_o && $past(init_done_o) &&
    (dac_a_code_o != $past(dac_a_code_o) || dac_b_code_o != $past(dac_b_code_o)) |->
    quiet <= 4'h6) else $error("dac moved without cause");
  chk_quiet_ref: assert property ($changed(ref_enabled_o) |-> quiet <= 4'h6)
    else $error("reference moved without frame");
endmodule // drc_ctrl_asserts

bind drc_ctrl drc_ctrl_asserts chk (.clk_sys_i, .sys_rst_i, .sclk_i, .sync_n_i, .sdin_i,
  .reset_n_i, .reset_level_select_i, .load_dac_strobe_n_i, .dac_a_code_o, .dac_b_code_o,
  .ref_enabled_o, .init_done_o);

// ==== drc_host_model.sv ====
// host serial master: clock idle high, data changed on rising clock
// assumes: called on a system clock rising edge; the lead is doubled, so any lead keeps edges off that clock
module drc_host_model (
  output logic sclk_o,   // serial clock, runs only within frames
  output logic sync_n_o, // frame sync, active low
  output logic sdin_o    // serial data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk_o = 1'b1;
    sync_n_o = 1'b1;
    sdin_o = 1'b0;
  end
  // sends nbits msb first with a 32 ns clock
  task automatic send(input logic [23:0] w, input int nbits, input int lead);
    logic [23:0] sh;
    sh = w;
    #(2 * lead + 3);
    sync_n_o = 1'b0;
    repeat (nbits) begin
      sdin_o = sh[23];
      sh = {sh[22:0], sh[23]};
      #16 sclk_o = 1'b0;
      #16 sclk_o = 1'b1;
    end
    #16 sync_n_o = 1'b1;
    sdin_o = ~sdin_o;
  endtask
endmodule // drc_host_model

// ==== tb_drc_ctrl.sv ====
// self-checking bench of the dac reset/reference control block
// assumes: drc_ctrl_asserts bound, host model drives the serial link
module tb_drc_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import drc_pkg::*;
  logic        clk_sys_i, sys_rst_i, reset_n, sel, s, load_dac_strobe_n, ref_on, done;
  wire logic   sclk, sync_n, sdin;
  logic [11:0] da, db, exp_a, exp_b, clr, d;
  logic [3:0]  a;
  logic [23:0] w;
  int          i, mismatches, total_checks;
  drc_ctrl dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .sync_n_i(sync_n),
    .sdin_i(sdin), .reset_n_i(reset_n), .reset_level_select_i(sel),
    .load_dac_strobe_n_i(load_dac_strobe_n), .dac_a_code_o(da), .dac_b_code_o(db),
    .ref_enabled_o(ref_on), .init_done_o(done));
  drc_host_model host (.sclk_o(sclk), .sync_n_o(sync_n), .sdin_o(sdin));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  function automatic logic [23:0] word(logic [3:0] c, logic [3:0] ad, logic [11:0] dt, logic [3:0] lo);
    return {c, ad, dt, lo};
  endfunction
  task automatic frame(input logic [23:0] fw, input int n);
    host.send(fw, n, $urandom_range(4));
    cyc(8);
  endtask
  task automatic expchk();
    chk(da, exp_a);
    chk(db, exp_b);
  endtask
  initial begin
    cyc(50000);
    mismatches++;
    close_out();
  end
  initial begin
    void'($urandom(32'h002a));
    s = 1'($urandom_range(1));
    clr = s ? MID_SCALE : ZERO_SCALE;
    sys_rst_i = 1'b1;
    reset_n = 1'b0;
    sel = ~s;
    load_dac_strobe_n = 1'b1;
    cyc(10);
    sys_rst_i <= 1'b0;
    cyc(10);
    load_dac_strobe_n <= 1'b0;
    cyc(3);
    load_dac_strobe_n <= 1'b1;
    sel <= s;
    cyc(30);
    chk({11'h0, done}, 12'h0);
    chk(da, clr);
    reset_n <= 1'b1;
    for (i = 0; i < 60 && done !== 1'b1; i++) cyc(1);
    if (done !== 1'b1) begin
      mismatches++;
      close_out();
    end
    $display("power-up done");
    exp_a = clr;
    exp_b = clr;
    chk({11'h0, ref_on}, 12'h1);
    expchk();
    repeat (6) begin
      a = 4'($urandom);
      d = 12'($urandom);
      frame(word(CMD_WRITE_UPDATE, a, d, 4'h0), 24);
      if (a[0]) exp_a = d;
      if (a[3]) exp_b = d;
      expchk();
    end
    frame(word(CMD_WRITE_UPDATE, 4'h9, ~exp_a, 4'h0), 23);
    expchk();
    frame(word(CMD_WRITE_UPDATE, 4'h9, ~exp_a, 4'h0), 25);
    expchk();
    $display("writes done");
    d = 12'($urandom);
    frame(word(CMD_LOAD_DAC_STROBE_MASK, 4'h0, 12'h0, 4'h1), 24);
    frame(word(CMD_WRITE_INPUT, 4'h9, d, 4'h0), 24);
    expchk();
    load_dac_strobe_n <= 1'b0;
    cyc(6);
    load_dac_strobe_n <= 1'b1;
    exp_b = d;
    expchk();
    frame(word(CMD_LOAD_DAC_STROBE_MASK, 4'h0, 12'h0, 4'h0), 24);
    load_dac_strobe_n <= 1'b0;
    cyc(6);
    load_dac_strobe_n <= 1'b1;
    exp_a = d;
    expchk();
    $display("load strobe done");
    for (i = 0; i < 3; i++) begin
      w = 24'($urandom);
      w[23:20] = CMD_REF_SETUP;
      w[0] = (i != 1);
      frame(w, 24);
      chk({11'h0, ref_on}, {11'h0, ~w[0]});
    end
    frame(word(CMD_SOFT_RESET, 4'($urandom), 12'($urandom), 4'h0), 24);
    exp_a = clr;
    exp_b = clr;
    expchk();
    chk({11'h0, ref_on}, 12'h1);
    $display("reference and soft reset done");
    frame(word(CMD_WRITE_UPDATE, 4'h9, ~clr, 4'h0), 24);
    reset_n <= 1'b0;
    cyc(8);
    expchk();
    frame(word(CMD_WRITE_UPDATE, 4'h9, d, 4'h0), 24);
    expchk();
    reset_n <= 1'b1;
    cyc(8);
    expchk();
    $display("reset pin done");
    close_out();
  end
endmodule // tb_drc_ctrl
